// ---- tb/jtag_tester_model.sv ----
// Behavioural boundary-scan tester driving the test access pins
`default_nettype none
module jtag_tester_model (
   // Serial return line
   input wire logic tdo_i,
   // Test access drive, lines float high when released
   output logic tck_o,
   output logic tms_o,
   output logic tdi_o,
   output logic drive_o
);
   timeunit 1ns;
   timeprecision 100ps;

   // Clock parked low, lines released
   initial begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b1;
      drive_o = 1'b0;
   end

   // One 80 ns period; lines move just after the falling edge
   task automatic tick(input logic tms, input logic tdi, output logic tdo);
      #2;
      tms_o = tms;
      tdi_o = tdi;
      drive_o = 1'b1;
      #38;
      tck_o = 1'b1;
      tdo = tdo_i;
      #40;
      tck_o = 1'b0;
   endtask

   // Released lines, clock still running
   task automatic idle_ticks(input int n);
      #2;
      drive_o = 1'b0;
      tms_o = ~tms_o;
      tdi_o = ~tdi_o;
      repeat (n) begin
         #38 tck_o = 1'b1;
         #40 tck_o = 1'b0;
      end
   endtask

   // Five high edges then park in idle
   task automatic reset_tap();
      logic d;
      repeat (5) tick(1'b1, 1'b1, d);
      tick(1'b0, 1'b1, d);
   endtask

   // Combined instruction scan, first controller bits go first
   task automatic ir_scan(input logic [10:0] ir, output logic [10:0] cap);
      logic d;
      tick(1'b1, 1'b1, d);
      tick(1'b1, 1'b1, d);
      tick(1'b0, 1'b1, d);
      tick(1'b0, 1'b1, d);
      for (int i = 0; i < 11; i++) tick(i == 10, ir[i], cap[i]);
      tick(1'b1, 1'b1, d);
      tick(1'b0, 1'b1, d);
   endtask

   // Data scan of n bits from idle back to idle
   task automatic dr_scan(input int n, input logic [63:0] din, output logic [63:0] dout);
      logic d;
      dout = '0;
      tick(1'b1, 1'b1, d);
      tick(1'b0, 1'b1, d);
      tick(1'b0, 1'b1, d);
      for (int i = 0; i < n; i++) tick(i == n - 1, din[i], dout[i]);
      tick(1'b1, 1'b1, d);
      tick(1'b0, 1'b1, d);
   endtask
endmodule // jtag_tester_model
`default_nettype wire

// ---- tb/test_dual_tap_boundary_scan_port.sv ----
// Self-checking bench of the dual boundary-scan port
`include "tap_regs.svh"
`default_nettype none
module test_dual_tap_boundary_scan_port;
   timeunit 1ns;
   timeprecision 100ps;

   localparam logic [31:0] ID_VAL = 32'h2468_ace1; // Arbitrary value
   logic clk_i;
   logic sys_rst_i;
   wire logic tck;
   wire logic tms_drv;
   wire logic tdi_drv;
   wire logic drive;
   wire logic tms_line;
   wire logic tdi_line;
   wire logic tdo_line;
   logic tdo_o;
   logic tdo_oe_n_o;
   logic [3:0] core_out_i;
   logic [3:0] core_oe_n_i;
   logic [3:0] pin_in_i;
   logic [3:0] pin_out_o;
   logic [3:0] pin_oe_n_o;
   int failures;
   int check_count;
   int cycles;
   logic [10:0] cap;
   logic [63:0] dout;

   // Pad pull-ups and the shared serial return
   assign tms_line = drive ? tms_drv : 1'b1;
   assign tdi_line = drive ? tdi_drv : 1'b1;
   assign tdo_line = tdo_oe_n_o ? ~tdo_o : tdo_o; // Released line shows the inverse

   dual_tap_port #(.N_IN(4), .N_OUT(4), .N_NC(2), .IDCODE(ID_VAL)) uut (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .tck_i(tck), .tms_i(tms_line), .tdi_i(tdi_line),
      .tdo_o(tdo_o), .tdo_oe_n_o(tdo_oe_n_o), .core_out_i(core_out_i), .core_oe_n_i(core_oe_n_i),
      .pin_in_i(pin_in_i), .pin_out_o(pin_out_o), .pin_oe_n_o(pin_oe_n_o));

   jtag_tester_model tester (.tdo_i(tdo_line), .tck_o(tck), .tms_o(tms_drv), .tdi_o(tdi_drv), .drive_o(drive));

   // System clock
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   task automatic check_eq(input logic [63:0] seen, input logic [63:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("FAIL %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // Bounded wait for the pin ring to settle after a crossing
   task automatic wait_pins(input logic [3:0] eo, input logic [3:0] eoe, input bit use_out);
      int n;
      n = 0;
      while (n < 20 && !(pin_oe_n_o === eoe && (!use_out || pin_out_o === eo))) begin
         @(posedge clk_i);
         #1;
         n++;
      end
   endtask

   // Reset held with the test clock running
   task automatic sc_reset();
      logic d;
      repeat (3) @(posedge clk_i);
      repeat (3) tester.tick(1'b1, 1'b1, d);
      check_eq(64'(tdo_oe_n_o), 64'h1);
      check_eq(64'(pin_oe_n_o), 64'hf);
      @(posedge clk_i);
      #1 sys_rst_i = 1'b0;
      tester.idle_ticks(3);
      tester.reset_tap();
   endtask

   // Instruction capture pattern of both controllers, then both in bypass
   task automatic sc_ir_capture();
      tester.ir_scan({`TAP_OP2_BYPASS, `TAP_OP1_BYPASS}, cap);
      check_eq(64'(cap), 64'({`TAP_IR2_CAPT, `TAP_IR1_CAPT}));
   endtask

   // Two bypass bits delay the pattern by two clocks
   task automatic sc_bypass();
      tester.dr_scan(10, 64'h2ce, dout);
      check_eq(dout, 64'({8'hce, 2'b00}));
      check_eq(64'(tdo_oe_n_o), 64'h1);
   endtask

   // Sample the ring while preloading 9, then drive it out
   task automatic sc_sample_extest();
      tester.ir_scan({`TAP_OP2_SAMPLE, `TAP_OP1_BYPASS}, cap);
      tester.dr_scan(11, 64'h012, dout);
      check_eq(dout, 64'({2'b00, 4'ha, 4'h5, 1'b0}));
      tester.ir_scan({`TAP_OP2_EXTEST, `TAP_OP1_BYPASS}, cap);
      wait_pins(4'h9, 4'h0, 1'b1);
      check_eq(64'(pin_out_o), 64'h9);
      check_eq(64'(pin_oe_n_o), 64'h0);
   endtask

   // Pins float and the path is bypass
   task automatic sc_highz();
      tester.ir_scan({`TAP_OP2_HIGHZ, `TAP_OP1_BYPASS}, cap);
      wait_pins(4'h0, 4'hf, 1'b0);
      check_eq(64'(pin_oe_n_o), 64'hf);
      tester.dr_scan(4, 64'hd, dout);
      check_eq(dout, 64'h4);
   endtask

   // Floating mode select resets; identification returns
   task automatic sc_idcode();
      logic d;
      tester.idle_ticks(5);
      tester.tick(1'b0, 1'b1, d);
      wait_pins(4'h5, 4'h3, 1'b1);
      check_eq(64'({pin_oe_n_o, pin_out_o}), 64'h35);
      tester.dr_scan(33, 64'h0, dout);
      check_eq(dout, 64'({ID_VAL, 1'b0}));
   endtask

   // Hang guard
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         $display("FAIL %0t: run too long", $time);
         tally_and_finish();
      end
   end

   initial begin
      sys_rst_i = 1'b1;
      core_out_i = 4'h5;
      core_oe_n_i = 4'h3;
      pin_in_i = 4'ha;
      failures = 0;
      check_count = 0;
      cycles = 0;
      sc_reset();
      sc_ir_capture();
      sc_bypass();
      sc_sample_extest();
      sc_highz();
      sc_idcode();
      tally_and_finish();
   end
endmodule // test_dual_tap_boundary_scan_port
`default_nettype wire

// ---- verilog/dual_tap_port.sv ----
// Two chained boundary-scan controllers with boundary register and pin control
`include "tap_regs.svh"
`default_nettype none
module dual_tap_port #(
   parameter int N_IN = 4,
   parameter int N_OUT = 4,
   parameter int N_NC = 2,
   parameter logic [`TAP_ID_W-1:0] IDCODE = `TAP_IDCODE_DEF
) (
   // System clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // Test access pins
   input wire logic tck_i,
   input wire logic tms_i,
   input wire logic tdi_i,
   output logic tdo_o,
   output logic tdo_oe_n_o,
   // Core side of the output pins
   input wire logic [N_OUT-1:0] core_out_i,
   input wire logic [N_OUT-1:0] core_oe_n_i,
   // Pin ring
   input wire logic [N_IN-1:0] pin_in_i,
   output logic [N_OUT-1:0] pin_out_o,
   output logic [N_OUT-1:0] pin_oe_n_o
);
   localparam int BS_W = N_NC + N_IN + N_OUT;

   // Test clock domain
   logic [1:0] rst_sync_reg;
   logic rst_tck;
   logic [N_IN-1:0] pin_in_m_reg;
   logic [N_IN-1:0] pin_in_s_reg;
   logic [N_OUT-1:0] pin_out_m_reg;
   logic [N_OUT-1:0] pin_out_s_reg;
   logic byp2_reg;
   logic byp1_reg;
   logic [`TAP_ID_W-1:0] id_reg;
   logic [BS_W-1:0] bsr_reg;
   logic [N_OUT-1:0] upd_reg;
   logic upd_tgl_reg;
   logic tdo_reg;
   logic tdo_oe_n_reg;
   logic extest_lvl_reg;
   logic highz_lvl_reg;
   // System clock domain
   logic upd_tgl_m_reg;
   logic upd_tgl_s_reg;
   logic upd_tgl_d_reg;
   logic [N_OUT-1:0] word_reg;
   logic extest_m_reg;
   logic extest_s_reg;
   logic highz_m_reg;
   logic highz_s_reg;
   logic [N_OUT-1:0] pin_out_reg;
   logic [N_OUT-1:0] pin_oe_n_reg;

   tap_ctl_if #(.IR_W(`TAP_IR1_W)) c1 ();
   tap_ctl_if #(.IR_W(`TAP_IR2_W)) c2 ();

   // Power-up reset for the test domain, released on the test clock
   always_ff @(posedge tck_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rst_sync_reg <= 2'h3;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b0};
      end
   end
   assign rst_tck = rst_sync_reg[1];

   // Controller links; device two faces serial in, device one serial out
   wire dev2_so;
   wire in_ir_path = (c2.state == tap_pkg::ST_SH_IR);
   assign c2.tck = tck_i;
   assign c2.rst = rst_tck;
   assign c2.tms = tms_i;
   assign c2.tdi = tdi_i;
   assign c1.tck = tck_i;
   assign c1.rst = rst_tck;
   assign c1.tms = tms_i;
   assign c1.tdi = dev2_so;

   tap_fsm #(.IR_W(`TAP_IR2_W), .IR_RST(`TAP_OP2_IDCODE), .IR_CAPT(`TAP_IR2_CAPT)) u_tap2 (
      .c(c2)
   );
   tap_fsm #(.IR_W(`TAP_IR1_W), .IR_RST(`TAP_IR1_RST), .IR_CAPT(`TAP_IR1_CAPT)) u_tap1 (
      .c(c1)
   );

   // Second controller opcode decode; unknown codes fall back to bypass
   wire op_extest = (c2.ir == `TAP_OP2_EXTEST);
   wire op_highz = (c2.ir == `TAP_OP2_HIGHZ);
   wire op_sample = (c2.ir == `TAP_OP2_SAMPLE);
   wire op_ident = (c2.ir == `TAP_OP2_IDCODE);
   wire tap_pkg::dr_sel_t sel2 = (op_extest || op_sample) ? tap_pkg::DR_BOUND :
      op_ident ? tap_pkg::DR_IDENT : tap_pkg::DR_BYPASS;
   // First controller only has bypass, whatever its code
   wire dev1_bypass = (c1.ir == `TAP_OP1_BYPASS);

   // State decodes shared by both controllers
   wire st_cap_dr = (c2.state == tap_pkg::ST_CAP_DR);
   wire st_sh_dr = (c2.state == tap_pkg::ST_SH_DR);
   wire st_upd_dr = (c2.state == tap_pkg::ST_UPD_DR);
   wire shifting = st_sh_dr || in_ir_path;

   // Serial path selection: exactly one register per controller
   wire dr2_so = (sel2 == tap_pkg::DR_IDENT) ? id_reg[0] :
      (sel2 == tap_pkg::DR_BOUND) ? bsr_reg[0] : byp2_reg;
   assign dev2_so = in_ir_path ? c2.ir_so : dr2_so;
   wire dev1_so = in_ir_path ? c1.ir_so : byp1_reg;

   // Pad values sampled twice on the test clock before capture
   always_ff @(posedge tck_i or posedge rst_tck) begin
      if (rst_tck) begin
         pin_in_m_reg <= '0;
         pin_in_s_reg <= '0;
         pin_out_m_reg <= '0;
         pin_out_s_reg <= '0;
      end else begin
         pin_in_m_reg <= pin_in_i;
         pin_in_s_reg <= pin_in_m_reg;
         pin_out_m_reg <= pin_out_reg;
         pin_out_s_reg <= pin_out_m_reg;
      end
   end
   wire [BS_W-1:0] cap_vec = {{N_NC{1'b0}}, pin_in_s_reg, pin_out_s_reg};

   // Bypass cells: zero on capture, one stage in shift
   always_ff @(posedge tck_i or posedge rst_tck) begin
      if (rst_tck) begin
         byp2_reg <= 1'b0;
         byp1_reg <= 1'b0;
      end else if (st_cap_dr) begin
         byp2_reg <= 1'b0;
         byp1_reg <= 1'b0;
      end else if (st_sh_dr) begin
         byp2_reg <= tdi_i;
         byp1_reg <= dr2_so;
      end
   end

   // Identification register: hardwired code, shifted toward LSB
   always_ff @(posedge tck_i or posedge rst_tck) begin
      if (rst_tck) begin
         id_reg <= '0;
      end else if (st_cap_dr && sel2 == tap_pkg::DR_IDENT) begin
         id_reg <= IDCODE;
      end else if (st_sh_dr && sel2 == tap_pkg::DR_IDENT) begin
         id_reg <= {tdi_i, id_reg[`TAP_ID_W-1:1]};
      end
   end

   // Boundary register: snapshot of the ring, then shift
   always_ff @(posedge tck_i or posedge rst_tck) begin
      if (rst_tck) begin
         bsr_reg <= '0;
      end else if (st_cap_dr && sel2 == tap_pkg::DR_BOUND) begin
         bsr_reg <= cap_vec;
      end else if (st_sh_dr && sel2 == tap_pkg::DR_BOUND) begin
         bsr_reg <= {tdi_i, bsr_reg[BS_W-1:1]};
      end
   end

   // Parallel output latches update on the falling edge, toggle marks new word
   always_ff @(negedge tck_i or posedge rst_tck) begin
      if (rst_tck) begin
         upd_reg <= '0;
         upd_tgl_reg <= 1'b0;
      end else if (st_upd_dr && sel2 == tap_pkg::DR_BOUND) begin
         upd_reg <= bsr_reg[N_OUT-1:0];
         upd_tgl_reg <= ~upd_tgl_reg;
      end
   end

   // Serial out and its enable change on the falling edge
   always_ff @(negedge tck_i or posedge rst_tck) begin
      if (rst_tck) begin
         tdo_reg <= 1'b0;
         tdo_oe_n_reg <= 1'b1;
      end else begin
         tdo_reg <= dev1_so;
         tdo_oe_n_reg <= ~shifting;
      end
   end
   assign tdo_o = tdo_reg;
   assign tdo_oe_n_o = tdo_oe_n_reg;

   // Mode decodes registered so that no decode glitch reaches the crossing
   always_ff @(posedge tck_i or posedge rst_tck) begin
      if (rst_tck) begin
         extest_lvl_reg <= 1'b0;
         highz_lvl_reg <= 1'b0;
      end else begin
         extest_lvl_reg <= op_extest;
         highz_lvl_reg <= op_highz;
      end
   end

   // Mode levels and update toggle cross into the system domain
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         extest_m_reg <= 1'b0;
         extest_s_reg <= 1'b0;
         highz_m_reg <= 1'b0;
         highz_s_reg <= 1'b0;
         upd_tgl_m_reg <= 1'b0;
         upd_tgl_s_reg <= 1'b0;
         upd_tgl_d_reg <= 1'b0;
      end else begin
         extest_m_reg <= extest_lvl_reg;
         extest_s_reg <= extest_m_reg;
         highz_m_reg <= highz_lvl_reg;
         highz_s_reg <= highz_m_reg;
         upd_tgl_m_reg <= upd_tgl_reg;
         upd_tgl_s_reg <= upd_tgl_m_reg;
         upd_tgl_d_reg <= upd_tgl_s_reg;
      end
   end

   // Latched word is stable for several test clocks after its toggle
   wire word_new = upd_tgl_s_reg ^ upd_tgl_d_reg;
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         word_reg <= '0;
      end else if (word_new) begin
         word_reg <= upd_reg;
      end
   end

   // Pin drivers: float under high-impedance, preload under external test
   wire [N_OUT-1:0] pin_out_next = extest_s_reg ? word_reg : core_out_i;
   wire [N_OUT-1:0] pin_oe_n_next = highz_s_reg ? {N_OUT{1'b1}} :
      extest_s_reg ? {N_OUT{1'b0}} : core_oe_n_i;
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pin_out_reg <= '0;
         pin_oe_n_reg <= '1;
      end else begin
         pin_out_reg <= pin_out_next;
         pin_oe_n_reg <= pin_oe_n_next;
      end
   end
   assign pin_out_o = pin_out_reg;
   assign pin_oe_n_o = pin_oe_n_reg;

   // Checks on the test clock domain
   tms_reset_a: assert property (@(posedge tck_i) disable iff (rst_tck)
      tms_i [*5] |=> c2.state == tap_pkg::ST_RESET && c1.state == tap_pkg::ST_RESET)
      else $error("five high mode-select edges did not reset");
   bypass_delay_a: assert property (@(posedge tck_i) disable iff (rst_tck)
      (st_sh_dr && sel2 == tap_pkg::DR_BYPASS) [*3] |-> byp1_reg == $past(tdi_i, 2))
      else $error("double bypass delay is not two clocks");
   tdo_idle_a: assert property (@(posedge tck_i) disable iff (rst_tck)
      $past(shifting) == shifting |-> tdo_oe_n_o == !shifting)
      else $error("serial out enable does not follow shift states");
   ir_idcode_a: assert property (@(posedge tck_i) disable iff (rst_tck)
      c2.state == tap_pkg::ST_RESET |-> c2.ir == `TAP_OP2_IDCODE && c1.ir == `TAP_IR1_RST)
      else $error("reset state did not load identification instruction");
   id_capture_a: assert property (@(posedge tck_i) disable iff (rst_tck)
      st_cap_dr && op_ident |=> id_reg == IDCODE)
      else $error("identification code not captured");
   bsr_capture_a: assert property (@(posedge tck_i) disable iff (rst_tck)
      st_cap_dr && (op_sample || op_extest) |=> bsr_reg == $past(cap_vec))
      else $error("boundary snapshot not captured");
   bsr_shift_a: assert property (@(posedge tck_i) disable iff (rst_tck)
      st_sh_dr && sel2 == tap_pkg::DR_BOUND |=> bsr_reg[BS_W-1] == $past(tdi_i))
      else $error("serial in did not enter at the top bit");
   tdo_source_a: assert property (@(negedge tck_i) disable iff (rst_tck)
      st_sh_dr |=> tdo_o == $past(byp1_reg))
      else $error("serial out not taken from first controller");
   // Bypass cells clear on capture
   byp_capture_a: assert property (@(posedge tck_i) disable iff (rst_tck)
      st_cap_dr |=> !byp2_reg && !byp1_reg)
      else $error("bypass cells not cleared on capture");
   // Identification register takes serial in at its top bit
   id_shift_a: assert property (@(posedge tck_i) disable iff (rst_tck)
      st_sh_dr && sel2 == tap_pkg::DR_IDENT |=> id_reg[`TAP_ID_W-1] == $past(tdi_i))
      else $error("identification register did not shift");
   // Identification instruction puts the code register in the path
   id_path_a: assert property (@(posedge tck_i) disable iff (rst_tck)
      op_ident && !in_ir_path |-> dev2_so == id_reg[0])
      else $error("identification register not in the path");
   // External test puts the boundary register in the path
   bsr_path_a: assert property (@(posedge tck_i) disable iff (rst_tck)
      op_extest && !in_ir_path |-> dev2_so == bsr_reg[0])
      else $error("boundary register not in the path");
   // First controller bypass follows the second controller output
   dev1_path_a: assert property (@(posedge tck_i) disable iff (rst_tck)
      st_sh_dr |=> byp1_reg == $past(dr2_so))
      else $error("controllers not chained in data shift");
   // Update latches the low boundary cells
   preload_latch_a: assert property (@(posedge tck_i) disable iff (rst_tck)
      st_upd_dr && sel2 == tap_pkg::DR_BOUND |=> upd_reg == $past(bsr_reg[N_OUT-1:0]))
      else $error("preload pattern not latched");
   // High-impedance keeps the bypass cell in the path
   highz_path_a: assert property (@(posedge tck_i) disable iff (rst_tck)
      op_highz && !in_ir_path |-> dev2_so == byp2_reg)
      else $error("bypass not selected under high-impedance");
   // Instruction shift leaves through the first controller
   tdo_ir_a: assert property (@(negedge tck_i) disable iff (rst_tck)
      in_ir_path |=> tdo_o == $past(c1.ir_so))
      else $error("instruction bits not shifted to serial out");
   // Checks on the system clock domain
   highz_pins_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      highz_s_reg |=> pin_oe_n_o == {N_OUT{1'b1}})
      else $error("pins not floated under high-impedance");
   extest_drive_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      extest_s_reg && !highz_s_reg |=> pin_oe_n_o == '0 && pin_out_o == $past(word_reg))
      else $error("preloaded values not driven under external test");
   // Outside the test modes the pins follow the core
   pin_core_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !extest_s_reg && !highz_s_reg |=> pin_out_o == $past(core_out_i) && pin_oe_n_o == $past(core_oe_n_i))
      else $error("pins do not follow the core");
   // Preload word taken only once its toggle has settled
   word_cross_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      word_new |=> word_reg == $past(upd_reg))
      else $error("preload word lost in the crossing");

   // Main scenarios
   bypass_shift_c: cover property (@(posedge tck_i) disable iff (rst_tck)
      (st_sh_dr && sel2 == tap_pkg::DR_BYPASS && dev1_bypass) [*3]);
   ident_shift_c: cover property (@(posedge tck_i) disable iff (rst_tck)
      st_cap_dr && op_ident ##1 st_sh_dr [*8]);
   preload_c: cover property (@(posedge tck_i) disable iff (rst_tck)
      st_upd_dr && op_sample);
   extest_c: cover property (@(posedge clk_i) disable iff (sys_rst_i) extest_s_reg && word_new);
   highz_c: cover property (@(posedge clk_i) disable iff (sys_rst_i) highz_s_reg);
endmodule : dual_tap_port
`default_nettype wire

// ---- verilog/tap_ctl_if.sv ----
// Carrier between a test controller core and its data path
`default_nettype none
interface tap_ctl_if #(parameter int IR_W = 8);
   logic tck;
   logic rst;
   logic tms;
   logic tdi;
   tap_pkg::tap_state_t state;
   logic [IR_W-1:0] ir;
   logic ir_so;

   // Controller core side
   modport ctrl (input tck, input rst, input tms, input tdi, output state, output ir, output ir_so);
   // Data path side
   modport user (output tck, output rst, output tms, output tdi, input state, input ir, input ir_so);
endinterface : tap_ctl_if
`default_nettype wire

// ---- verilog/tap_fsm.sv ----
// Sixteen-state test controller with its instruction register
`default_nettype none
module tap_fsm #(
   parameter int IR_W = 8,
   parameter logic [IR_W-1:0] IR_RST = '1,
   parameter logic [IR_W-1:0] IR_CAPT = IR_W'(1)
) (
   // Link to the data path
   tap_ctl_if.ctrl c
);
   tap_pkg::tap_state_t state_reg;
   tap_pkg::tap_state_t state_next;
   logic [IR_W-1:0] ir_sh_reg;
   logic [IR_W-1:0] ir_reg;

   // Transition table driven by mode select
   function automatic tap_pkg::tap_state_t next_st(input tap_pkg::tap_state_t s, input logic m);
      case (s)
         tap_pkg::ST_RESET: next_st = m ? tap_pkg::ST_RESET : tap_pkg::ST_IDLE;
         tap_pkg::ST_IDLE: next_st = m ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
         tap_pkg::ST_SEL_DR: next_st = m ? tap_pkg::ST_SEL_IR : tap_pkg::ST_CAP_DR;
         tap_pkg::ST_CAP_DR: next_st = m ? tap_pkg::ST_EX1_DR : tap_pkg::ST_SH_DR;
         tap_pkg::ST_SH_DR: next_st = m ? tap_pkg::ST_EX1_DR : tap_pkg::ST_SH_DR;
         tap_pkg::ST_EX1_DR: next_st = m ? tap_pkg::ST_UPD_DR : tap_pkg::ST_PAU_DR;
         tap_pkg::ST_PAU_DR: next_st = m ? tap_pkg::ST_EX2_DR : tap_pkg::ST_PAU_DR;
         tap_pkg::ST_EX2_DR: next_st = m ? tap_pkg::ST_UPD_DR : tap_pkg::ST_SH_DR;
         tap_pkg::ST_UPD_DR: next_st = m ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
         tap_pkg::ST_SEL_IR: next_st = m ? tap_pkg::ST_RESET : tap_pkg::ST_CAP_IR;
         tap_pkg::ST_CAP_IR: next_st = m ? tap_pkg::ST_EX1_IR : tap_pkg::ST_SH_IR;
         tap_pkg::ST_SH_IR: next_st = m ? tap_pkg::ST_EX1_IR : tap_pkg::ST_SH_IR;
         tap_pkg::ST_EX1_IR: next_st = m ? tap_pkg::ST_UPD_IR : tap_pkg::ST_PAU_IR;
         tap_pkg::ST_PAU_IR: next_st = m ? tap_pkg::ST_EX2_IR : tap_pkg::ST_PAU_IR;
         tap_pkg::ST_EX2_IR: next_st = m ? tap_pkg::ST_UPD_IR : tap_pkg::ST_SH_IR;
         tap_pkg::ST_UPD_IR: next_st = m ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
         default: next_st = tap_pkg::ST_RESET;
      endcase
   endfunction

   assign state_next = next_st(state_reg, c.tms);

   // State advances on the rising test clock edge
   always_ff @(posedge c.tck or posedge c.rst) begin
      if (c.rst) begin
         state_reg <= tap_pkg::ST_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   // Instruction shift stage: capture 01, shift in at the top
   always_ff @(posedge c.tck or posedge c.rst) begin
      if (c.rst) begin
         ir_sh_reg <= IR_RST;
      end else if (state_reg == tap_pkg::ST_CAP_IR) begin
         ir_sh_reg <= IR_CAPT;
      end else if (state_reg == tap_pkg::ST_SH_IR) begin
         ir_sh_reg <= {c.tdi, ir_sh_reg[IR_W-1:1]};
      end
   end

   // Active instruction changes on the falling edge
   always_ff @(negedge c.tck or posedge c.rst) begin
      if (c.rst) begin
         ir_reg <= IR_RST;
      end else if (state_reg == tap_pkg::ST_RESET) begin
         ir_reg <= IR_RST;
      end else if (state_reg == tap_pkg::ST_UPD_IR) begin
         ir_reg <= ir_sh_reg;
      end
   end

   assign c.state = state_reg;
   assign c.ir = ir_reg;
   assign c.ir_so = ir_sh_reg[0];

   // Instruction update takes the shifted pattern
   ir_update_a: assert property (@(posedge c.tck) disable iff (c.rst)
      state_reg == tap_pkg::ST_UPD_IR |-> ir_reg == ir_sh_reg)
      else $error("instruction not updated from shift stage");
   // Capture loads 01 in the low bits
   ir_capture_a: assert property (@(posedge c.tck) disable iff (c.rst)
      state_reg == tap_pkg::ST_CAP_IR |=> ir_sh_reg[1:0] == 2'b01)
      else $error("instruction capture pattern wrong");
   // Instruction bits enter at the top of the shift stage
   ir_shift_a: assert property (@(posedge c.tck) disable iff (c.rst)
      state_reg == tap_pkg::ST_SH_IR |=> ir_sh_reg[IR_W-1] == $past(c.tdi))
      else $error("instruction bit did not enter at the top");
   // Active instruction holds outside update and reset
   ir_hold_a: assert property (@(posedge c.tck) disable iff (c.rst)
      state_reg != tap_pkg::ST_UPD_IR && state_reg != tap_pkg::ST_RESET |-> $stable(ir_reg))
      else $error("active instruction changed outside update");
endmodule : tap_fsm
`default_nettype wire

// ---- verilog/tap_pkg.sv ----
// Types shared by the boundary-scan test port modules
`default_nettype none
package tap_pkg;

   // Controller states, Gray coded along the usual path
   typedef enum logic [3:0] {
      ST_RESET   = 4'h0,
      ST_IDLE    = 4'h1,
      ST_SEL_DR  = 4'h3,
      ST_CAP_DR  = 4'h2,
      ST_SH_DR   = 4'h6,
      ST_EX1_DR  = 4'h7,
      ST_PAU_DR  = 4'h5,
      ST_EX2_DR  = 4'h4,
      ST_UPD_DR  = 4'hc,
      ST_SEL_IR  = 4'hd,
      ST_CAP_IR  = 4'hf,
      ST_SH_IR   = 4'he,
      ST_EX1_IR  = 4'ha,
      ST_PAU_IR  = 4'hb,
      ST_EX2_IR  = 4'h9,
      ST_UPD_IR  = 4'h8
   } tap_state_t;

   // Data register placed in the serial path
   typedef enum logic [1:0] {
      DR_BYPASS = 2'h0,
      DR_IDENT  = 2'h1,
      DR_BOUND  = 2'h2
   } dr_sel_t;

endpackage : tap_pkg
`default_nettype wire

// ---- verilog/tap_regs.svh ----
// Constants of the dual boundary-scan test port
`ifndef TAP_REGS_SVH
`define TAP_REGS_SVH

// Instruction register widths of the two chained controllers
`define TAP_IR1_W 3
`define TAP_IR2_W 8

// First controller opcodes and reset value
`define TAP_OP1_BYPASS 3'h7
`define TAP_IR1_RST 3'h7

// Second controller opcodes
`define TAP_OP2_BYPASS 8'hff
`define TAP_OP2_EXTEST 8'h00
`define TAP_OP2_HIGHZ 8'h07
`define TAP_OP2_SAMPLE 8'h01
`define TAP_OP2_IDCODE 8'h0f

// Instruction capture pattern, low two bits 01
`define TAP_IR1_CAPT 3'h1
`define TAP_IR2_CAPT 8'h01

// Identification register width and default code (value arbitrary)
`define TAP_ID_W 32
`define TAP_IDCODE_DEF 32'h1234_5671

// Consecutive high mode-select edges that force the reset state
`define TAP_TMS_RST_EDGES 5

`endif
